// ### cache_freeze_control_block_chan.sv
// Purpose: one block coherence channel: base address and word count with start pulse
// Assumes: software loads the base before the count
// Notes: count above the maximum launches a zero-word operation
`timescale 1ns/100ps
`default_nettype none
module cache_freeze_control_block_chan
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic base_wr,
   input wire logic count_wr,
   input wire logic [31:0] wdata,
   output logic [31:0] base,
   output logic [15:0] count,
   output logic [15:0] op_words,
   output logic start
);
   // base holds whatever software wrote, no reset value
   always_ff @(posedge sys_clk)
   begin
      if (base_wr)
      begin
         base <= wdata;
      end
   end

   // stored count, readable
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         count <= cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_RST_COUNT;
      end
      else if (count_wr)
      begin
         count <= wdata[15:0];
      end
   end

   // launch on count write, clamp illegal counts to zero words
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         start <= 1'b0;
         op_words <= 16'h0000;
      end
      else
      begin
         start <= count_wr;
         if (count_wr)
         begin
            if (wdata[15:0] > cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_MAX_WORDS)
            begin
               op_words <= 16'h0000;
            end
            else
            begin
               op_words <= wdata[15:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### cache_freeze_control_chk_sva.sv
// Purpose: port checker for cache_freeze_control_regs
// Assumes: one clock, async active-low reset
// Notes: bound below to every instance
`timescale 1ns/100ps
`default_nettype none
module cache_freeze_control_chk
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] module_count_strap,
   input wire logic [3:0] module_identity_strap,
   input wire logic l1_program_global_invalidate,
   input wire logic l1_data_global_drop,
   input wire logic cache_freeze_control,
   input wire logic [2:0] cache_size_select,
   input wire cache_freeze_control_pkg::cache_freeze_control_size_t cache_size,
   input wire logic block_start,
   input wire cache_freeze_control_pkg::cache_freeze_control_op_t block_op,
   input wire logic [31:0] block_base,
   input wire logic [15:0] block_words
);
   // access-phase decodes
   wire logic acc = psel && penable;
   wire logic cfg = acc && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_CONFIG;
   wire logic wb_wr = acc && pwrite && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WB_COUNT;
   wire logic wi_wr = acc && pwrite && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WI_COUNT;
   wire logic cnt_wr = wb_wr || wi_wr;
   wire logic dinv = cfg && pwrite && pwdata[8];
   wire logic [15:0] wcnt = pwdata[15:0];
   wire logic [3:0] wlow = pwdata[3:0];
   wire logic hit = paddr inside {16'h0000, 16'h4000, 16'h4004, 16'h4010, 16'h4014};
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   a_wb_launch: assert property (wb_wr |-> ##2 block_start && block_op == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OP_WRITEBACK)
      else $error("writeback op not launched");
   a_wi_launch: assert property (wi_wr |-> ##2 block_start && block_op == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OP_WB_INVAL)
      else $error("wb-inval op not launched");
   a_start_cause: assert property (block_start |-> $past(cnt_wr, 2))
      else $error("start without count write");
   a_word_clamp: assert property (cnt_wr |-> ##2 block_words ==
      (($past(wcnt, 2) > cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_MAX_WORDS) ? 16'h0000 : $past(wcnt, 2)))
      else $error("launched word count wrong");
   a_prog_pulse: assert property (cfg && pwrite && pwdata[9] |=> l1_program_global_invalidate)
      else $error("program invalidate missing");
   a_data_cause: assert property (l1_data_global_drop |-> $past(dinv))
      else $error("data invalidate without cause");
   a_cfg_hold: assert property (cfg && pwrite |=> {cache_freeze_control, cache_size_select} == $past(wlow))
      else $error("freeze or size not stored");
   a_size_map: assert property (cache_size == ((cache_size_select > 3'h4) ? 3'h5 : cache_size_select))
      else $error("size decode wrong");
   a_cfg_read: assert property (cfg && !pwrite |-> prdata == {4'h0, module_count_strap, 4'h0,
      module_identity_strap, 12'h000, cache_freeze_control, cache_size_select})
      else $error("config readback wrong");
   a_bad_addr: assert property (acc && !hit |-> pslverr)
      else $error("no error on unmapped offset");
   c_wi_zero: cover property (block_start && block_op == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OP_WB_INVAL && block_words == 16'h0000);
   c_prog_inv: cover property (l1_program_global_invalidate);
   c_bad_addr: cover property (acc && pslverr);
   c_wb_launch: cover property (block_start && block_op == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OP_WRITEBACK);
endmodule
bind cache_freeze_control_regs cache_freeze_control_chk i_cache_freeze_control_chk (.*);
`default_nettype wire

// ### cache_freeze_control_pkg.sv
// Purpose: constants for the level-2 cache configuration and block coherence registers
// Assumes: apb slave, 32-bit data, byte addresses below
// Notes: offsets are byte offsets inside the block's apb window
package cache_freeze_control_pkg;
   // register byte offsets
   localparam logic [15:0] CACHE_FREEZE_CONTROL_OFF_CONFIG = 16'h0000;
   localparam logic [15:0] CACHE_FREEZE_CONTROL_OFF_WB_BASE = 16'h4000;
   localparam logic [15:0] CACHE_FREEZE_CONTROL_OFF_WB_COUNT = 16'h4004;
   localparam logic [15:0] CACHE_FREEZE_CONTROL_OFF_WI_BASE = 16'h4010;
   localparam logic [15:0] CACHE_FREEZE_CONTROL_OFF_WI_COUNT = 16'h4014;
   // configuration field positions
   localparam int CACHE_FREEZE_CONTROL_POS_COUNT_LO = 24;
   localparam int CACHE_FREEZE_CONTROL_POS_IDENT_LO = 16;
   localparam int CACHE_FREEZE_CONTROL_POS_PROG_INV = 9;
   localparam int CACHE_FREEZE_CONTROL_POS_DATA_INV = 8;
   localparam int CACHE_FREEZE_CONTROL_POS_FREEZE = 3;
   localparam int CACHE_FREEZE_CONTROL_POS_SIZE_LO = 0;
   // reset values
   localparam logic CACHE_FREEZE_CONTROL_RST_FREEZE = 1'b0;
   localparam logic [2:0] CACHE_FREEZE_CONTROL_RST_SIZE = 3'h0;
   localparam logic [15:0] CACHE_FREEZE_CONTROL_RST_COUNT = 16'h0000;
   // largest legal block word count
   localparam logic [15:0] CACHE_FREEZE_CONTROL_MAX_WORDS = 16'hffe0;
   // block operation kinds
   typedef enum logic [0:0]
   {
      CACHE_FREEZE_CONTROL_OP_WRITEBACK = 1'b0,
      CACHE_FREEZE_CONTROL_OP_WB_INVAL = 1'b1
   } cache_freeze_control_op_t;
   // decoded cache size
   typedef enum logic [2:0]
   {
      CACHE_FREEZE_CONTROL_SIZE_OFF = 3'h0,
      CACHE_FREEZE_CONTROL_SIZE_32K = 3'h1,
      CACHE_FREEZE_CONTROL_SIZE_64K = 3'h2,
      CACHE_FREEZE_CONTROL_SIZE_128K = 3'h3,
      CACHE_FREEZE_CONTROL_SIZE_256K = 3'h4,
      CACHE_FREEZE_CONTROL_SIZE_MAX = 3'h5
   } cache_freeze_control_size_t;
endpackage

// ### cache_freeze_control_regs.sv
// Purpose: apb register block for level-2 cache configuration and block coherence
// Assumes: one clock, apb master per the amba protocol, zero wait states
// Notes: module count and identity come from straps captured after reset
`timescale 1ns/100ps
`default_nettype none
module cache_freeze_control_regs
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] module_count_strap,
   input wire logic [3:0] module_identity_strap,
   output logic l1_program_global_invalidate,
   output logic l1_data_global_drop,
   output logic cache_freeze_control,
   output logic [2:0] cache_size_select,
   output cache_freeze_control_pkg::cache_freeze_control_size_t cache_size,
   output logic block_start,
   output cache_freeze_control_pkg::cache_freeze_control_op_t block_op,
   output logic [31:0] block_base,
   output logic [15:0] block_words
);
   logic wr_en; // write accepted this edge
   logic rd_sel; // read setup phase
   logic hit; // address maps a register
   logic [3:0] module_count_minus_one; // captured strap
   logic [3:0] module_identity_number; // captured strap
   logic straps_taken; // strap capture done
   logic [31:0] wb_base; // writeback base
   logic [15:0] wb_count; // writeback count
   logic [15:0] wb_words; // clamped writeback words
   logic wb_start; // writeback launch
   logic [31:0] wi_base; // wb-invalidate base
   logic [15:0] wi_count; // wb-invalidate count
   logic [15:0] wi_words; // clamped wb-invalidate words
   logic wi_start; // wb-invalidate launch
   logic [31:0] next_prdata; // read mux

   // zero-wait apb, writes on access phase
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_sel = psel && !penable && !pwrite;

   // address decode
   always_comb
   begin
      unique case (paddr)
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_CONFIG,
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WB_BASE,
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WB_COUNT,
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WI_BASE,
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WI_COUNT: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // unmapped access answers with an error
   assign pslverr = psel && penable && !hit;

   // straps caught once after reset release
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         straps_taken <= 1'b0;
         module_count_minus_one <= 4'h0;
         module_identity_number <= 4'h0;
      end
      else if (!straps_taken)
      begin
         straps_taken <= 1'b1;
         module_count_minus_one <= module_count_strap;
         module_identity_number <= module_identity_strap;
      end
   end

   // configuration control fields
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cache_freeze_control <= cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_RST_FREEZE;
         cache_size_select <= cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_RST_SIZE;
      end
      else if (wr_en && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_CONFIG)
      begin
         cache_freeze_control <= pwdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_FREEZE];
         cache_size_select <= pwdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_SIZE_LO +: 3];
      end
   end

   // global invalidate pulses, write-only bits
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         l1_program_global_invalidate <= 1'b0;
         l1_data_global_drop <= 1'b0;
      end
      else
      begin
         l1_program_global_invalidate <= wr_en && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_CONFIG
            && pwdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_PROG_INV];
         l1_data_global_drop <= wr_en && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_CONFIG
            && pwdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_DATA_INV];
      end
   end

   // size decode
   always_comb
   begin
      // codes five to seven give maximum
      unique case (cache_size_select)
         3'h0: cache_size = cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_SIZE_OFF;
         3'h1: cache_size = cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_SIZE_32K;
         3'h2: cache_size = cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_SIZE_64K;
         3'h3: cache_size = cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_SIZE_128K;
         3'h4: cache_size = cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_SIZE_256K;
         default: cache_size = cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_SIZE_MAX;
      endcase
   end

   cache_freeze_control_block_chan u_wb
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .base_wr(wr_en && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WB_BASE),
      .count_wr(wr_en && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WB_COUNT),
      .wdata(pwdata),
      .base(wb_base),
      .count(wb_count),
      .op_words(wb_words),
      .start(wb_start)
   );

   cache_freeze_control_block_chan u_wi
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .base_wr(wr_en && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WI_BASE),
      .count_wr(wr_en && paddr == cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WI_COUNT),
      .wdata(pwdata),
      .base(wi_base),
      .count(wi_count),
      .op_words(wi_words),
      .start(wi_start)
   );

   // block operation request towards the cache controller
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         block_start <= 1'b0;
         block_op <= cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OP_WRITEBACK;
         block_base <= 32'h0000_0000;
         block_words <= 16'h0000;
      end
      else
      begin
         block_start <= wb_start || wi_start;
         if (wb_start)
         begin
            block_op <= cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OP_WRITEBACK;
            block_base <= wb_base;
            block_words <= wb_words;
         end
         else if (wi_start)
         begin
            block_op <= cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OP_WB_INVAL;
            block_base <= wi_base;
            block_words <= wi_words;
         end
      end
   end

   // read mux, reserved and write-only read zero
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_CONFIG:
         begin
            next_prdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_COUNT_LO +: 4] = module_count_minus_one;
            next_prdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_IDENT_LO +: 4] = module_identity_number;
            next_prdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_FREEZE] = cache_freeze_control;
            next_prdata[cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_POS_SIZE_LO +: 3] = cache_size_select;
         end
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WB_COUNT: next_prdata[15:0] = wb_count;
         cache_freeze_control_pkg::CACHE_FREEZE_CONTROL_OFF_WI_COUNT: next_prdata[15:0] = wi_count;
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   // read data registered in setup, valid in access phase
   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (rd_sel)
      begin
         prdata <= next_prdata;
      end
   end
endmodule
`default_nettype wire

// ### test_cache_freeze_control_regs.sv
// Purpose: self-checking bench for cache_freeze_control_regs
// Assumes: apb master, 4 ns clock
// Notes: straps held constant through the run
`timescale 1ns/100ps
`default_nettype none
module test_cache_freeze_control_regs;
   // bench drives and design outputs
   logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
   logic l1_program_global_invalidate, l1_data_global_drop, cache_freeze_control, block_start;
   logic [15:0] paddr, block_words;
   logic [31:0] pwdata, prdata, block_base, rd;
   logic [3:0] module_count_strap, module_identity_strap;
   logic [2:0] cache_size_select;
   cache_freeze_control_pkg::cache_freeze_control_size_t cache_size;
   cache_freeze_control_pkg::cache_freeze_control_op_t block_op;
   int num_errors, cmp_count;
   cache_freeze_control_regs i_cache_freeze_control_regs
   (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .module_count_strap(module_count_strap),
      .module_identity_strap(module_identity_strap),
      .l1_program_global_invalidate(l1_program_global_invalidate),
      .l1_data_global_drop(l1_data_global_drop),
      .cache_freeze_control(cache_freeze_control),
      .cache_size_select(cache_size_select),
      .cache_size(cache_size),
      .block_start(block_start),
      .block_op(block_op),
      .block_base(block_base),
      .block_words(block_words)
   );
   // free-running clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // verdict and end of run
   task close_out;
      $display("mismatches %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // one comparison
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer, held until pready
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         num_errors++;
         close_out;
      end
   endtask
   // bounded wait for the launch pulse
   task wait_start;
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      while (block_start !== 1'b1 && n < 8);
      chk("start_delay", n, 1);
      if (block_start !== 1'b1)
         close_out;
      // launch pulse lasts one cycle only
      @(posedge sys_clk);
      #1;
      chk("start_fall", block_start, 1'b0);
   endtask
   // configuration fields, pulses and size codes
   task t_cfg;
      apb(1'b0, 16'h0000, 32'h0);
      chk("cfg_reset", rd, 32'h050a_0000);
      chk("ident", rd[19:16], 4'ha);
      apb(1'b1, 16'h0000, 32'hffff_ffff);
      #1;
      chk("prog_inv", l1_program_global_invalidate, 1'b1);
      chk("data_inv", l1_data_global_drop, 1'b1);
      chk("freeze", cache_freeze_control, 1'b1);
      apb(1'b0, 16'h0000, 32'h0);
      chk("cfg_rd", rd, 32'h050a_000f);
      for (int i = 0; i < 8; i++)
      begin
         apb(1'b1, 16'h0000, i);
         #1;
         chk("size", cache_size, (i > 4) ? 5 : i);
         chk("size_sel", cache_size_select, i);
         chk("no_inv", l1_program_global_invalidate, 1'b0);
         chk("no_dinv", l1_data_global_drop, 1'b0);
         chk("thaw", cache_freeze_control, 1'b0);
      end
   endtask
   // block launches, clamp and readback
   task t_block;
      apb(1'b1, 16'h4000, 32'hdead_beef);
      apb(1'b1, 16'h4004, 32'hffff_0010);
      wait_start;
      chk("wb_op", block_op, 1'b0);
      chk("wb_base", block_base, 32'hdead_beef);
      chk("wb_words", block_words, 16'h0010);
      apb(1'b0, 16'h4004, 32'h0);
      chk("wb_cnt_rd", rd, 32'h0000_0010);
      apb(1'b1, 16'h4004, 32'h0000_ffff);
      wait_start;
      chk("wb_clamp", block_words, 16'h0000);
      chk("wb_op2", block_op, 1'b0);
      apb(1'b0, 16'h4004, 32'h0);
      chk("wb_raw_rd", rd, 32'h0000_ffff);
      apb(1'b0, 16'h4000, 32'h0);
      chk("base_rd", rd, 32'h0);
      apb(1'b1, 16'h4010, 32'hffff_ffff);
      apb(1'b1, 16'h4014, 32'h0000_ffe1);
      wait_start;
      chk("wi_op", block_op, 1'b1);
      chk("wi_base", block_base, 32'hffff_ffff);
      chk("wi_clamp", block_words, 16'h0000);
      apb(1'b1, 16'h4014, 32'h0000_ffe0);
      wait_start;
      chk("wi_max", block_words, 16'hffe0);
      apb(1'b0, 16'h0100, 32'h0);
      chk("bad_rd", rd, 32'h0);
      chk("bad_err", er, 1'b1);
      chk("ready", pready, 1'b1);
   endtask
   // reset, then the scenarios
   initial
   begin
      resetn <= 1'b0;
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= 16'h0000;
      pwdata <= 32'h0;
      module_count_strap <= 4'h5;
      module_identity_strap <= 4'ha;
      num_errors = 0;
      cmp_count = 0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      t_cfg;
      t_block;
      close_out;
   end
endmodule
`default_nettype wire
